// ---- core/gpp_pkg.sv ----
// Purpose: Shared constants and types for the sensed GPIO port block
// Assumes: AXI4-Lite register access, 32-bit data, eight pins per group
// Notes: One register per aligned word; printed offsets are register indexes
package gpp_pkg;

  localparam int NPIN = 8;

  // ------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [5:0] IDX_DIR = 6'h00;
  localparam logic [5:0] IDX_DIRECTION_SET_STROBE = 6'h01;
  localparam logic [5:0] IDX_DIRECTION_CLEAR_STROBE = 6'h02;
  localparam logic [5:0] IDX_DIRECTION_TOGGLE_STROBE = 6'h03;
  localparam logic [5:0] IDX_OUT = 6'h04;
  localparam logic [5:0] IDX_OUTPUT_SET_STROBE = 6'h05;
  localparam logic [5:0] IDX_OUTPUT_CLEAR_STROBE = 6'h06;
  localparam logic [5:0] IDX_OUTPUT_TOGGLE_STROBE = 6'h07;
  localparam logic [5:0] IDX_IN = 6'h08;
  localparam logic [5:0] IDX_FLAGS = 6'h09;
  localparam logic [5:0] IDX_PINCTRL = 6'h10;
  // Alias window mirrors direction, output, input and flags
  localparam logic [5:0] IDX_ALIAS_DIR = 6'h20;
  localparam logic [5:0] IDX_ALIAS_OUT = 6'h21;
  localparam logic [5:0] IDX_ALIAS_IN = 6'h22;
  localparam logic [5:0] IDX_ALIAS_FLAGS = 6'h23;

  // ------------------------------------------------------------
  // Per-pin control field positions and reset values
  // ------------------------------------------------------------
  localparam int CTL_INV_POS = 7;
  localparam int CTL_PULL_POS = 3;
  localparam int CTL_SENSE_LSB = 0;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_OUT = 8'h00;
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Dead time after a synchronous interrupt, in cycles
  localparam int DEAD_CYCLES = 3;
  localparam logic [1:0] DEAD_LOAD = 2'(DEAD_CYCLES);

  typedef enum logic [2:0] {
    SENSE_INTDISABLE = 3'b000,
    SENSE_ANY_EDGE = 3'b001,
    SENSE_RISING = 3'b010,
    SENSE_FALLING = 3'b011,
    SENSE_INPUT_DISABLE = 3'b100,
    SENSE_LEVEL = 3'b101
  } gpp_sense_type;

  typedef struct packed {
    logic invert_enable;
    logic [2:0] rsvd;
    logic pullup_enable;
    gpp_sense_type sense_select;
  } gpp_ctl_type;

  // Pad-facing signals travel together
  typedef struct packed {
    logic [NPIN-1:0] drv;
    logic [NPIN-1:0] oe;
    logic [NPIN-1:0] pull;
    logic [NPIN-1:0] ibuf_en;
  } gpp_pad_type;

endpackage

// ---- core/gpp_port.sv ----
// Purpose: Eight-pin GPIO port with set/clear/toggle strobes and pin sense
// Assumes: AXI4-Lite slave, one mclk domain, pads sampled through two flops
// Notes: Async pins, still sampled through the two flops but without dead time, are chosen by the ASYNC_PINS parameter
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module gpp_port
  import gpp_pkg::*;
#(
  parameter logic [NPIN-1:0] ASYNC_PINS = 8'h01
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPIN-1:0] pad_in,
  output gpp_pad_type pad_ff,
  output logic [NPIN-1:0] event_out_ff,
  output logic port_irq_ff,
  output logic wake_ff
);

  // ------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------
  // Fold alias addresses onto the regular register they mirror
  function automatic logic [5:0] map_idx(input logic [7:0] addr);
    logic [5:0] idx;
    idx = addr[7:2];
    case (idx)
      IDX_ALIAS_DIR: map_idx = IDX_DIR;
      IDX_ALIAS_OUT: map_idx = IDX_OUT;
      IDX_ALIAS_IN: map_idx = IDX_IN;
      IDX_ALIAS_FLAGS: map_idx = IDX_FLAGS;
      default: map_idx = idx;
    endcase
  endfunction

  function automatic logic idx_valid(input logic [5:0] idx);
    idx_valid = (idx <= IDX_FLAGS) ||
                (idx >= IDX_PINCTRL && idx < IDX_PINCTRL + 6'(NPIN));
  endfunction

  // ------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------
  logic [7:0] awaddr_ff;
  logic aw_held_ff;
  logic [7:0] wdata_ff;
  logic w_held_ff;
  logic wr_go;
  logic [5:0] wr_idx;
  logic [7:0] dir_ff;
  logic [7:0] out_ff;
  logic [7:0] flags_ff;
  gpp_ctl_type ctl_ff [NPIN];

  assign wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_idx = map_idx(awaddr_ff);

  // Address and data captured in either order; one write at a time
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_ff && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held_ff && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        // Only the low byte lane carries register data
        wdata_ff <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= idx_valid(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Direction and output registers with atomic strobes
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dir_ff <= RST_DIR;
    end else if (wr_go) begin
      case (wr_idx)
        IDX_DIR: dir_ff <= wdata_ff;
        IDX_DIRECTION_SET_STROBE: dir_ff <= dir_ff | wdata_ff;
        IDX_DIRECTION_CLEAR_STROBE: dir_ff <= dir_ff & ~wdata_ff;
        IDX_DIRECTION_TOGGLE_STROBE: dir_ff <= dir_ff ^ wdata_ff;
        default: dir_ff <= dir_ff;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      out_ff <= RST_OUT;
    end else if (wr_go) begin
      case (wr_idx)
        IDX_OUT: out_ff <= wdata_ff;
        IDX_OUTPUT_SET_STROBE: out_ff <= out_ff | wdata_ff;
        IDX_OUTPUT_CLEAR_STROBE: out_ff <= out_ff & ~wdata_ff;
        IDX_OUTPUT_TOGGLE_STROBE, IDX_IN: out_ff <= out_ff ^ wdata_ff;
        default: out_ff <= out_ff;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Per-pin control, sensing and pad drive
  // ------------------------------------------------------------
  logic [NPIN-1:0] sync1_ff;
  logic [NPIN-1:0] sync2_ff;
  logic [NPIN-1:0] prev_ff;
  logic [NPIN-1:0] hit;
  logic [NPIN-1:0] in_val;
  logic [NPIN-1:0] in_dis;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      logic [1:0] dead_ff;
      logic sensed;

      // Pin control writes at index 0x10 + n
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          ctl_ff[gi] <= gpp_ctl_type'(RST_CTL);
        end else if (wr_go && wr_idx == IDX_PINCTRL + 6'(gi)) begin
          ctl_ff[gi] <= gpp_ctl_type'(wdata_ff);
        end
      end

      assign in_dis[gi] = ctl_ff[gi].sense_select == SENSE_INPUT_DISABLE;

      // Synchronizer holds still while input disabled to save power
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end else if (!in_dis[gi]) begin
          sync1_ff[gi] <= pad_in[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end

      // Inversion after the synchronizer, so toggling it is an edge
      assign in_val[gi] = sync2_ff[gi] ^ ctl_ff[gi].invert_enable;

      // Previous value is frozen while disabled; a pending edge may fire later
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          prev_ff[gi] <= 1'b0;
        end else if (!in_dis[gi]) begin
          prev_ff[gi] <= in_val[gi];
        end
      end

      // Condition selection; a same-cycle invert/sense change may miss
      always_comb begin
        case (ctl_ff[gi].sense_select)
          SENSE_ANY_EDGE: sensed = in_val[gi] ^ prev_ff[gi];
          SENSE_RISING: sensed = in_val[gi] & ~prev_ff[gi];
          SENSE_FALLING: sensed = ~in_val[gi] & prev_ff[gi];
          SENSE_LEVEL: sensed = ~in_val[gi];
          default: sensed = 1'b0;
        endcase
      end

      // Synchronous pins get three dead cycles; async pins none
      assign hit[gi] = sensed && (dead_ff == 2'h0 || ASYNC_PINS[gi]);

      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          dead_ff <= 2'h0;
        end else if (hit[gi] && !ASYNC_PINS[gi]) begin
          dead_ff <= DEAD_LOAD;
        end else if (dead_ff != 2'h0) begin
          dead_ff <= dead_ff - 2'h1;
        end
      end

      // Pad drive: driver off and buffer on from reset
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          pad_ff.oe[gi] <= 1'b0;
          pad_ff.drv[gi] <= 1'b0;
          pad_ff.pull[gi] <= 1'b0;
          pad_ff.ibuf_en[gi] <= 1'b1;
          event_out_ff[gi] <= 1'b0;
        end else begin
          pad_ff.oe[gi] <= dir_ff[gi];
          pad_ff.drv[gi] <= out_ff[gi] ^ ctl_ff[gi].invert_enable;
          pad_ff.pull[gi] <= ctl_ff[gi].pullup_enable;
          pad_ff.ibuf_en[gi] <= !in_dis[gi];
          event_out_ff[gi] <= in_dis[gi] ? 1'b0 : sync2_ff[gi];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Interrupt flags and request
  // ------------------------------------------------------------
  logic [7:0] flag_clr;
  assign flag_clr = (wr_go && wr_idx == IDX_FLAGS) ? wdata_ff : 8'h00;

  // A new hit wins over a same-cycle clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_ff <= 8'h00;
    end else begin
      flags_ff <= (flags_ff & ~flag_clr) | hit;
    end
  end

  // Flags only set for enabled senses, so any flag requests
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      port_irq_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      port_irq_ff <= |((flags_ff & ~flag_clr) | hit);
      // Clock running here: every sense wakes; stopped-clock wake is outside
      wake_ff <= |hit;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------
  logic [5:0] rd_idx;
  logic [7:0] rd_byte;
  assign rd_idx = map_idx(s_axi_araddr);

  always_comb begin
    rd_byte = 8'h00;
    case (rd_idx)
      IDX_DIR, IDX_DIRECTION_SET_STROBE, IDX_DIRECTION_CLEAR_STROBE, IDX_DIRECTION_TOGGLE_STROBE: rd_byte = dir_ff;
      IDX_OUT, IDX_OUTPUT_SET_STROBE, IDX_OUTPUT_CLEAR_STROBE, IDX_OUTPUT_TOGGLE_STROBE: rd_byte = out_ff;
      IDX_IN: rd_byte = in_val & ~in_dis;
      IDX_FLAGS: rd_byte = flags_ff;
      default: begin
        if (rd_idx >= IDX_PINCTRL && rd_idx < IDX_PINCTRL + 6'(NPIN)) begin
          rd_byte = ctl_ff[rd_idx[2:0]];
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= idx_valid(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_dir_set;
    @(posedge mclk) disable iff (sys_rst)
      (wr_go && wr_idx == IDX_DIRECTION_SET_STROBE) |=> dir_ff == ($past(dir_ff) | $past(wdata_ff));
  endproperty
  a_dir_set: assert property (p_dir_set) else $error("dir set wrong");

  property p_dir_clr;
    @(posedge mclk) disable iff (sys_rst)
      (wr_go && wr_idx == IDX_DIRECTION_CLEAR_STROBE) |=> dir_ff == ($past(dir_ff) & ~$past(wdata_ff));
  endproperty
  a_dir_clr: assert property (p_dir_clr) else $error("dir clear wrong");

  property p_dir_tgl;
    @(posedge mclk) disable iff (sys_rst)
      (wr_go && wr_idx == IDX_DIRECTION_TOGGLE_STROBE) |=> dir_ff == ($past(dir_ff) ^ $past(wdata_ff));
  endproperty
  a_dir_tgl: assert property (p_dir_tgl) else $error("dir toggle wrong");

  property p_out_in_tgl;
    @(posedge mclk) disable iff (sys_rst)
      (wr_go && wr_idx == IDX_IN) |=> out_ff == ($past(out_ff) ^ $past(wdata_ff));
  endproperty
  a_out_in_tgl: assert property (p_out_in_tgl) else $error("in write toggle wrong");

  property p_oe_follows;
    @(posedge mclk) disable iff (sys_rst) 1'b1 |=> pad_ff.oe == $past(dir_ff);
  endproperty
  a_oe_follows: assert property (p_oe_follows) else $error("oe not from dir");

  // Every hit lands as a flag; a clear without a hit empties the flag
  property p_flag_keep;
    @(posedge mclk) disable iff (sys_rst)
      1'b1 |=> ((flags_ff & $past(hit)) == $past(hit)) &&
               ((flags_ff & $past(flag_clr) & ~$past(hit)) == 8'h00);
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("hit lost");

  property p_irq_level;
    @(posedge mclk) disable iff (sys_rst) 1'b1 |=> port_irq_ff == (flags_ff != 8'h00);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq mismatch");

  property p_dead0;
    @(posedge mclk) disable iff (sys_rst)
      (hit[3] && !ASYNC_PINS[3]) |=> !hit[3] [*3];
  endproperty
  a_dead0: assert property (p_dead0) else $error("dead time broken");

  property p_evt_zero;
    @(posedge mclk) disable iff (sys_rst) $past(in_dis[6]) |-> event_out_ff[6] == 1'b0;
  endproperty
  a_evt_zero: assert property (p_evt_zero) else $error("event not zero");

endmodule

// ---- verif/gpp_pad_model.sv ----
// Purpose: Board-side pad model for the sensed GPIO port
// Assumes: One pad per pin, bench decides which pins it drives
// Notes: Undriven, unpulled pads wander every cycle to expose floating reads
`timescale 1ns/10ps
module gpp_pad_model
  import gpp_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire gpp_pad_type pad,
  input wire logic [NPIN-1:0] ext_en,
  input wire logic [NPIN-1:0] ext_lvl,
  output logic [NPIN-1:0] pad_lvl
);
  logic [NPIN-1:0] float_ff;

  // ------------------------------------------------------------
  // Pad level resolution
  // ------------------------------------------------------------
  // Port driver first, then board source, then pullup, else noise
  always_comb begin
    for (int n = 0; n < NPIN; n++) begin
      if (pad.oe[n]) begin
        pad_lvl[n] = pad.drv[n];
      end else if (ext_en[n]) begin
        pad_lvl[n] = ext_lvl[n]; // Source holds level until told otherwise
      end else if (pad.pull[n]) begin
        pad_lvl[n] = 1'b1;
      end else begin
        pad_lvl[n] = float_ff[n];
      end
    end
  end

  // Floating pads show the inverse of their last level
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      float_ff <= '0;
    end else begin
      float_ff <= ~pad_lvl;
    end
  end
endmodule

// ---- verif/gpp_port_bench.sv ----
// Purpose: Self-checking bench for the sensed GPIO port
// Assumes: AXI4-Lite master tasks, pads from the board-side model
// Notes: Pin 3 is sync sensed; sense cases run from a table
`timescale 1ns/10ps
module gpp_port_bench;
  import gpp_pkg::*;
  localparam logic [4:0] FALL_T = 5'b11010;
  localparam logic [4:0] LOW_T = 5'b10000;
  localparam logic [4:0] RISE_T = 5'b10110;
  gpp_sense_type modes [5] = '{SENSE_INTDISABLE, SENSE_ANY_EDGE, SENSE_RISING,
    SENSE_FALLING, SENSE_LEVEL};
  logic mclk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr, ext_en, ext_lvl, pad_in, event_out;
  logic [31:0] wdata, rdata, rd_data;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, port_irq, wake;
  logic [1:0] bresp, rresp, last_resp;
  gpp_pad_type pad;
  int mismatches = 0;
  int comparisons = 0;
  int wakes = 0;
  int wakes_base;

  gpp_port DUT (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pad_in(pad_in), .pad_ff(pad), .event_out_ff(event_out),
    .port_irq_ff(port_irq), .wake_ff(wake));
  gpp_pad_model pads (.mclk(mclk), .sys_rst(sys_rst), .pad(pad), .ext_en(ext_en),
    .ext_lvl(ext_lvl), .pad_lvl(pad_in));

  // ------------------------------------------------------------
  // Clock, verdict and watchdog
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Wake is a one-cycle pulse, so count it on every edge
  always @(posedge mclk) begin
    if (wake === 1'b1) begin
      wakes++;
    end
  end

  // Whole run needs some hundreds of cycles; a hang stops far later
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    finish_test();
  end

  // ------------------------------------------------------------
  // Compare and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [5:0] idx, input logic [7:0] val);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge mclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    last_resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx);
    @(posedge mclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rd_data = rdata;
    last_resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    rd(idx);
    chk(rd_data[7:0], exp);
  endtask

  // Board changes pads, then waits past sync, flag and irq latency
  task automatic drive(input logic [7:0] lvl);
    @(posedge mclk);
    ext_lvl <= lvl;
    repeat (6) @(posedge mclk);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    ext_en = 8'hFF;
    ext_lvl = 8'h00;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    chk(pad.oe, 8'h00);
    chk(pad.ibuf_en, 8'hFF);
    rd_chk(IDX_DIR, 8'h00);
    // Direction strobes touch only the written ones
    wr(IDX_DIRECTION_SET_STROBE, 8'h31);
    rd_chk(IDX_DIR, 8'h31);
    wr(IDX_DIRECTION_CLEAR_STROBE, 8'h11);
    rd_chk(IDX_DIR, 8'h20);
    wr(IDX_DIRECTION_TOGGLE_STROBE, 8'h28);
    rd_chk(IDX_DIRECTION_SET_STROBE, 8'h08);
    wr(IDX_OUTPUT_SET_STROBE, 8'h0C);
    wr(IDX_OUTPUT_CLEAR_STROBE, 8'h04);
    rd_chk(IDX_OUT, 8'h08);
    wr(IDX_OUTPUT_TOGGLE_STROBE, 8'h09);
    wr(IDX_IN, 8'h81);
    rd_chk(IDX_OUT, 8'h80);
    chk(pad.oe, 8'h08);
    chk(pad.drv, 8'h80);
    // Alias window and an unmapped hole
    wr(IDX_ALIAS_DIR, 8'h0F);
    rd_chk(IDX_DIR, 8'h0F);
    wr(IDX_ALIAS_OUT, 8'h55);
    wr(IDX_ALIAS_IN, 8'h05);
    rd_chk(IDX_OUT, 8'h50);
    wr(6'h0A, 8'hFF);
    chk_resp(last_resp, RESP_SLVERR);
    rd(6'h0A);
    chk_resp(last_resp, RESP_SLVERR);
    rd_chk(IDX_DIR, 8'h0F);
    // Inputs: pin 1 inverted, pin 2 pulled up, pin 6 disabled
    wr(IDX_DIR, 8'h00);
    wr(6'h11, 8'h80);
    wr(6'h12, 8'h08);
    wr(6'h16, 8'h04);
    drive(8'hE5);
    rd_chk(IDX_IN, 8'hA7);
    chk(pad.pull, 8'h04);
    chk(pad.drv, 8'h52);
    chk(pad.ibuf_en, 8'hBF);
    chk(event_out, 8'hA5);
    @(posedge mclk);
    ext_en <= 8'hFB;
    drive(8'hE1);
    rd_chk(IDX_IN, 8'hA7);
    @(posedge mclk);
    ext_en <= 8'hFF;
    drive(8'hE5);
    // Every sense mode but input disable on pin 3: fall, hold low, rise
    for (int i = 0; i < 5; i++) begin
      drive(8'hED);
      wr(6'h13, {5'h00, modes[i]});
      drive(8'hED);
      wr(IDX_FLAGS, 8'hFF);
      drive(8'hE5);
      rd_chk(IDX_FLAGS, {4'h0, FALL_T[i], 3'h0});
      chk({7'h00, port_irq}, {7'h00, FALL_T[i]});
      wr(IDX_FLAGS, 8'hFF);
      drive(8'hE5);
      rd_chk(IDX_FLAGS, {4'h0, LOW_T[i], 3'h0});
      drive(8'hED);
      rd_chk(IDX_FLAGS, {4'h0, RISE_T[i], 3'h0});
    end
    // Zero writes keep a flag, a one through the alias clears it
    wr(6'h13, 8'h01);
    drive(8'hED);
    wr(IDX_FLAGS, 8'hFF);
    drive(8'hE5);
    wr(IDX_FLAGS, 8'h00);
    rd_chk(IDX_FLAGS, 8'h08);
    wr(IDX_ALIAS_FLAGS, 8'h08);
    rd_chk(IDX_ALIAS_FLAGS, 8'h00);
    chk({7'h00, port_irq}, 8'h00);
    // Invert change on a low pin gives a rising edge
    wr(6'h14, 8'h02);
    drive(8'hE5);
    wr(IDX_FLAGS, 8'hFF);
    wakes_base = wakes;
    wr(6'h14, 8'h82);
    drive(8'hE5);
    rd_chk(IDX_FLAGS, 8'h10);
    chk(8'(wakes - wakes_base), 8'h01);
    rd_chk(IDX_IN, 8'hB7);
    // Low byte lane off: the strobe write carries no ones
    @(posedge mclk);
    wstrb <= 4'h0;
    wr(IDX_OUTPUT_SET_STROBE, 8'hFF);
    rd_chk(IDX_OUT, 8'h50);
    finish_test();
  end
endmodule
